/* File: verilog/prb_top.sv */
// privileged special register bank with move-to/move-from access decode
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Overview of operation
// - 32-bit countdown timer raises exception on underflow
// - timer and clock words step on one tick input
// - user may read timer through register six
// - clock words user readable, supervisor writable
// - clock writes use different numbers than reads
// - exception saves address; return resumes there
// - exception saves status; return restores it
// - fault address held after data fault
// - fault cause recorded after data fault
// - other special registers supervisor only, except MQ also user readable
// - privilege taken from user mode bit
// - version register read only
// - four scratch registers, no side effects
// - external access control gates external words
// - four unified upper/lower translation pairs
// - multiply extension register loads and supplies
// - four-bit processor tag register
// - page table descriptor drives translation format
// - fixed 32-bit words, aligned fetch, fixed fields
// - only stores write memory
// ----------------------------------------------------------------
module prb_top #(
  parameter logic [31:0] VERSION_ID = 32'h0001_0001  // arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        TICK_CLK,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR_WORD,
  input  wire logic [31:0] INSTR_ADDR,
  input  wire logic [31:0] GPR_DATA,
  input  wire logic        EXC_TAKE,
  input  wire logic [31:0] EXC_PC,
  input  wire logic        EXC_DATA_FAULT,
  input  wire logic [31:0] EXC_FAULT_ADDR,
  input  wire logic [31:0] EXC_FAULT_CAUSE,
  input  wire logic        RET_REQ,
  input  wire logic        MSR_WE,
  input  wire logic [31:0] MSR_WDATA,
  input  wire logic        MQ_WE,
  input  wire logic [31:0] MQ_WDATA,
  output logic      [31:0] RESULT_DATA,
  output logic             RESULT_VALID,
  output logic             PRIV_EXC,
  output logic             ALIGN_EXC,
  output logic             TMR_EXC,
  output logic             EXT_GRANT,
  output logic             EXT_DENY,
  output logic             MEM_WRITE,
  output logic             RESUME_VALID,
  output logic      [31:0] RESUME_PC,
  output logic      [31:0] MSR_OUT,
  output logic      [31:0] MQ_OUT,
  output logic      [31:0] PT_DESC,
  output logic      [3:0]  PROC_TAG
);
  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic user_readable(input logic [9:0] n);
    user_readable = (n == prb_pkg::SPR_MQ) || (n == prb_pkg::SPR_CLK_UP_RD) ||
                    (n == prb_pkg::SPR_CLK_LO_RD) || (n == prb_pkg::SPR_TMR_USER);
  endfunction : user_readable
  function automatic logic in_range(input logic [9:0] n, input logic [9:0] base,
                                    input logic [9:0] cnt);
    in_range = (n >= base) && (n < base + cnt);
  endfunction : in_range
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] msr_r, tmr_r, clk_up_r, clk_lo_r, ret_addr_r, saved_st_r;
  logic [31:0] faddr_r, cause_r, ptdesc_r, ext_ctrl_r, mq_r;
  logic [3:0]  tag_r;
  logic [31:0] scr_r [4];
  logic [31:0] bt_r  [8];
  logic        tick_s1_r, tick_s2_r, tick_d_r;
  // ----------------------------------------------------------------
  // instruction decode, fixed field positions
  // ----------------------------------------------------------------
  logic [5:0] opc;
  logic [9:0] xo;
  logic [9:0] spr_n;
  logic       is_user, aligned, do_mf, do_mt, is_ext, is_store, spr_priv_ok, tick;
  logic       mt_ok, mf_ok;
  assign opc     = INSTR_WORD[prb_pkg::OPC_POS +: 6];
  assign xo      = INSTR_WORD[prb_pkg::XO_POS +: 10];
  assign spr_n   = {INSTR_WORD[15:11], INSTR_WORD[20:16]};
  assign is_user = msr_r[prb_pkg::USER_BIT_POS];
  assign aligned = (INSTR_ADDR[1:0] == 2'b00);
  assign do_mf   = INSTR_VALID && aligned && (opc == prb_pkg::OPC_XFORM) &&
                   (xo == prb_pkg::XO_MFSPR);
  assign do_mt   = INSTR_VALID && aligned && (opc == prb_pkg::OPC_XFORM) &&
                   (xo == prb_pkg::XO_MTSPR);
  assign is_ext  = INSTR_VALID && aligned && (opc == prb_pkg::OPC_XFORM) &&
                   ((xo == prb_pkg::XO_EXT_IN) || (xo == prb_pkg::XO_EXT_OUT));
  // only store opcodes reach memory; computational ones never do
  assign is_store = INSTR_VALID && aligned &&
                    (((opc >= 6'h24) && (opc <= 6'h27)) || (opc == 6'h2c) ||
                     (opc == 6'h2d) || (opc == 6'h2f) ||
                     ((opc >= 6'h34) && (opc <= 6'h37)) ||
                     ((opc == prb_pkg::OPC_XFORM) && (xo == prb_pkg::XO_STWX)));
  // supervisor may reach all; user only the readable few, and only by read
  assign spr_priv_ok = !is_user || (do_mf && user_readable(spr_n));
  assign mt_ok = do_mt && spr_priv_ok && !EXC_TAKE;
  assign mf_ok = do_mf && spr_priv_ok;
  // ----------------------------------------------------------------
  // tick input, synchronised and edge detected
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_d_r  <= 1'b0;
    end else begin
      tick_s1_r <= TICK_CLK;
      tick_s2_r <= tick_s1_r;
      tick_d_r  <= tick_s2_r;
    end
  end
  assign tick = tick_s2_r && !tick_d_r;
  // ----------------------------------------------------------------
  // countdown timer; a software write wins over a tick
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tmr_r   <= prb_pkg::TMR_RST;
      TMR_EXC <= 1'b0;
    end else begin
      TMR_EXC <= 1'b0;
      if (mt_ok && spr_n == prb_pkg::SPR_TMR) begin
        tmr_r <= GPR_DATA;
      end else if (tick) begin
        tmr_r <= tmr_r - 32'h0000_0001;
        TMR_EXC <= (tmr_r == prb_pkg::ZERO_RST);
      end
    end
  end
  // ----------------------------------------------------------------
  // real-time clock words, written only through the write numbers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_up_r <= prb_pkg::ZERO_RST;
      clk_lo_r <= prb_pkg::ZERO_RST;
    end else begin
      if (mt_ok && spr_n == prb_pkg::SPR_CLK_UP_WR) begin
        clk_up_r <= GPR_DATA;
      end else if (tick && clk_lo_r == 32'hffff_ffff) begin
        clk_up_r <= clk_up_r + 32'h0000_0001;
      end
      if (mt_ok && spr_n == prb_pkg::SPR_CLK_LO_WR) begin
        clk_lo_r <= GPR_DATA;
      end else if (tick) begin
        clk_lo_r <= clk_lo_r + 32'h0000_0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // exception save and return
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      msr_r        <= prb_pkg::MSR_RST;
      ret_addr_r   <= prb_pkg::ZERO_RST;
      saved_st_r   <= prb_pkg::ZERO_RST;
      RESUME_VALID <= 1'b0;
      RESUME_PC    <= prb_pkg::ZERO_RST;
    end else begin
      RESUME_VALID <= 1'b0;
      if (EXC_TAKE) begin
        ret_addr_r <= EXC_PC;
        saved_st_r <= msr_r;
        msr_r[prb_pkg::USER_BIT_POS] <= 1'b0;
      end else if (RET_REQ) begin
        msr_r        <= saved_st_r;
        RESUME_PC    <= ret_addr_r;
        RESUME_VALID <= 1'b1;
      end else begin
        if (MSR_WE) begin
          msr_r <= MSR_WDATA;
        end
        if (mt_ok && spr_n == prb_pkg::SPR_RET_ADDR) begin
          ret_addr_r <= GPR_DATA;
        end
        if (mt_ok && spr_n == prb_pkg::SPR_SAVED_ST) begin
          saved_st_r <= GPR_DATA;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // fault address and cause
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      faddr_r <= prb_pkg::ZERO_RST;
      cause_r <= prb_pkg::ZERO_RST;
    end else if (EXC_TAKE && EXC_DATA_FAULT) begin
      faddr_r <= EXC_FAULT_ADDR;
      cause_r <= EXC_FAULT_CAUSE;
    end else begin
      if (mt_ok && spr_n == prb_pkg::SPR_FADDR) begin
        faddr_r <= GPR_DATA;
      end
      if (mt_ok && spr_n == prb_pkg::SPR_CAUSE) begin
        cause_r <= GPR_DATA;
      end
    end
  end
  // ----------------------------------------------------------------
  // plain supervisor registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptdesc_r   <= prb_pkg::ZERO_RST;
      ext_ctrl_r <= prb_pkg::ZERO_RST;
      tag_r      <= '0;
      for (int i = 0; i < 4; i++) begin
        scr_r[i] <= prb_pkg::ZERO_RST;
      end
      for (int i = 0; i < 8; i++) begin
        bt_r[i] <= prb_pkg::ZERO_RST;
      end
    end else if (mt_ok) begin
      if (spr_n == prb_pkg::SPR_PTDESC) begin
        ptdesc_r <= GPR_DATA;
      end
      if (spr_n == prb_pkg::SPR_EXT_CTRL) begin
        ext_ctrl_r <= GPR_DATA;
      end
      if (spr_n == prb_pkg::SPR_TAG) begin
        tag_r <= GPR_DATA[prb_pkg::TAG_W-1:0];
      end
      if (in_range(spr_n, prb_pkg::SPR_SCR_BASE, 10'h004)) begin
        scr_r[spr_n[1:0]] <= GPR_DATA;
      end
      if (in_range(spr_n, prb_pkg::SPR_BT_BASE, 10'h008)) begin
        bt_r[spr_n[2:0]] <= GPR_DATA;
      end
    end
  end
  // ----------------------------------------------------------------
  // multiply extension register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mq_r <= prb_pkg::ZERO_RST;
    end else if (MQ_WE) begin
      mq_r <= MQ_WDATA;
    end else if (mt_ok && spr_n == prb_pkg::SPR_MQ) begin
      mq_r <= GPR_DATA;
    end
  end
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = prb_pkg::ZERO_RST;
    if (in_range(spr_n, prb_pkg::SPR_SCR_BASE, 10'h004)) begin
      rd_mux = scr_r[spr_n[1:0]];
    end else if (in_range(spr_n, prb_pkg::SPR_BT_BASE, 10'h008)) begin
      rd_mux = bt_r[spr_n[2:0]];
    end else begin
      case (spr_n)
        prb_pkg::SPR_MQ:        rd_mux = mq_r;
        prb_pkg::SPR_CLK_UP_RD: rd_mux = clk_up_r;
        prb_pkg::SPR_CLK_LO_RD: rd_mux = clk_lo_r;
        prb_pkg::SPR_TMR_USER:  rd_mux = tmr_r;
        prb_pkg::SPR_TMR:       rd_mux = tmr_r;
        prb_pkg::SPR_CAUSE:     rd_mux = cause_r;
        prb_pkg::SPR_FADDR:     rd_mux = faddr_r;
        prb_pkg::SPR_PTDESC:    rd_mux = ptdesc_r;
        prb_pkg::SPR_RET_ADDR:  rd_mux = ret_addr_r;
        prb_pkg::SPR_SAVED_ST:  rd_mux = saved_st_r;
        prb_pkg::SPR_EXT_CTRL:  rd_mux = ext_ctrl_r;
        prb_pkg::SPR_VERSION:   rd_mux = VERSION_ID;
        prb_pkg::SPR_TAG:       rd_mux = {28'h0000000, tag_r};
        default:                rd_mux = prb_pkg::ZERO_RST;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // registered answers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESULT_DATA  <= prb_pkg::ZERO_RST;
      RESULT_VALID <= 1'b0;
      PRIV_EXC     <= 1'b0;
      ALIGN_EXC    <= 1'b0;
      EXT_GRANT    <= 1'b0;
      EXT_DENY     <= 1'b0;
      MEM_WRITE    <= 1'b0;
    end else begin
      RESULT_VALID <= mf_ok;
      if (mf_ok) begin
        RESULT_DATA <= rd_mux;
      end
      PRIV_EXC  <= (do_mf || do_mt) && !spr_priv_ok;
      ALIGN_EXC <= INSTR_VALID && !aligned;
      EXT_GRANT <= is_ext && ext_ctrl_r[prb_pkg::EXT_EN_POS];
      EXT_DENY  <= is_ext && !ext_ctrl_r[prb_pkg::EXT_EN_POS];
      MEM_WRITE <= is_store;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MSR_OUT <= prb_pkg::MSR_RST;
      MQ_OUT  <= prb_pkg::ZERO_RST;
      PT_DESC <= prb_pkg::ZERO_RST;
      PROC_TAG <= '0;
    end else begin
      MSR_OUT  <= msr_r;
      MQ_OUT   <= mq_r;
      PT_DESC  <= ptdesc_r;
      PROC_TAG <= tag_r;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_user_bad;
    msr_r[prb_pkg::USER_BIT_POS] && do_mt && !EXC_TAKE;
  endsequence
  a_timer_underflow: assert property (
    tick && tmr_r == 32'h0 && !(mt_ok && spr_n == prb_pkg::SPR_TMR) |=> TMR_EXC
  ) else $error("timer underflow gave no exception");
  a_timer_steps: assert property (
    tick && !(mt_ok && spr_n == prb_pkg::SPR_TMR) |=> tmr_r == $past(tmr_r) - 32'h1
  ) else $error("timer did not step on tick");
  a_user_timer_read: assert property (
    INSTR_VALID && aligned && msr_r[prb_pkg::USER_BIT_POS] && do_mf &&
    spr_n == prb_pkg::SPR_TMR_USER |=> RESULT_VALID && !PRIV_EXC
  ) else $error("user timer read refused");
  // a tick carry may still move the upper clock word in that cycle
  a_user_no_write: assert property (
    s_user_bad |=> PRIV_EXC && ($stable(clk_up_r) || $past(tick)) && $stable(ptdesc_r)
  ) else $error("user write not refused");
  a_user_priv_read: assert property (
    msr_r[prb_pkg::USER_BIT_POS] && do_mf && spr_n == prb_pkg::SPR_RET_ADDR
    |=> PRIV_EXC && !RESULT_VALID
  ) else $error("user read of supervisor register");
  a_exc_save: assert property (
    EXC_TAKE |=> ret_addr_r == $past(EXC_PC) && saved_st_r == $past(msr_r) &&
                 !msr_r[prb_pkg::USER_BIT_POS]
  ) else $error("exception save wrong");
  a_ret_restore: assert property (
    !EXC_TAKE && RET_REQ |=> RESUME_VALID && RESUME_PC == $past(ret_addr_r)
                             ##1 MSR_OUT == $past(saved_st_r, 2)
  ) else $error("return did not restore");
  a_fault_record: assert property (
    EXC_TAKE && EXC_DATA_FAULT |=> faddr_r == $past(EXC_FAULT_ADDR) &&
                                   cause_r == $past(EXC_FAULT_CAUSE)
  ) else $error("fault not recorded");
  a_ext_gate: assert property (
    is_ext |=> EXT_GRANT == $past(ext_ctrl_r[prb_pkg::EXT_EN_POS]) && EXT_GRANT != EXT_DENY
  ) else $error("external access gating wrong");
  a_misalign_block: assert property (
    INSTR_VALID && !aligned |=> ALIGN_EXC && !RESULT_VALID && !MEM_WRITE
  ) else $error("misaligned word executed");
endmodule : prb_top

/* File: pkg/prb_pkg.sv */
// constants for the privileged register bank
package prb_pkg;

  // ----------------------------------------------------------------
  // special register numbers
  // ----------------------------------------------------------------
  localparam logic [9:0] SPR_MQ        = 10'h000;
  localparam logic [9:0] SPR_CLK_UP_RD = 10'h004;
  localparam logic [9:0] SPR_CLK_LO_RD = 10'h005;
  localparam logic [9:0] SPR_TMR_USER  = 10'h006;
  localparam logic [9:0] SPR_CAUSE     = 10'h012;
  localparam logic [9:0] SPR_FADDR     = 10'h013;
  localparam logic [9:0] SPR_CLK_UP_WR = 10'h014;
  localparam logic [9:0] SPR_CLK_LO_WR = 10'h015;
  localparam logic [9:0] SPR_TMR       = 10'h016;
  localparam logic [9:0] SPR_PTDESC    = 10'h019;
  localparam logic [9:0] SPR_RET_ADDR  = 10'h01a;
  localparam logic [9:0] SPR_SAVED_ST  = 10'h01b;
  localparam logic [9:0] SPR_SCR_BASE  = 10'h110;
  localparam logic [9:0] SPR_EXT_CTRL  = 10'h11a;
  localparam logic [9:0] SPR_VERSION   = 10'h11f;
  localparam logic [9:0] SPR_BT_BASE   = 10'h210;
  localparam logic [9:0] SPR_TAG       = 10'h3ff;

  // ----------------------------------------------------------------
  // instruction fields and opcodes
  // ----------------------------------------------------------------
  localparam int         OPC_POS    = 26;
  localparam int         XO_POS     = 1;
  localparam logic [5:0] OPC_XFORM  = 6'h1f;
  localparam logic [9:0] XO_MFSPR   = 10'h153;
  localparam logic [9:0] XO_MTSPR   = 10'h1d3;
  localparam logic [9:0] XO_EXT_IN  = 10'h136;
  localparam logic [9:0] XO_EXT_OUT = 10'h1b6;
  localparam logic [9:0] XO_STWX    = 10'h097;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          USER_BIT_POS = 14;
  localparam int          EXT_EN_POS   = 31;
  localparam int          TAG_W        = 4;
  localparam logic [31:0] MSR_RST      = 32'h0000_0000;
  localparam logic [31:0] TMR_RST      = 32'hffff_ffff;
  localparam logic [31:0] ZERO_RST     = 32'h0000_0000;

endpackage : prb_pkg

/* File: testbench/prb_top_bench.sv */
// self-checking bench for the privileged register bank
`timescale 1ns/1ns
module prb_top_bench;
  localparam logic [31:0] VER = 32'h0001_0001;
  localparam logic [9:0] RW_LIST [20] = '{prb_pkg::SPR_MQ, prb_pkg::SPR_CAUSE, prb_pkg::SPR_FADDR,
    prb_pkg::SPR_PTDESC, prb_pkg::SPR_RET_ADDR, prb_pkg::SPR_SAVED_ST, 10'h110, 10'h111, 10'h112,
    10'h113, prb_pkg::SPR_EXT_CTRL, 10'h210, 10'h211, 10'h212, 10'h213, 10'h214, 10'h215, 10'h216,
    10'h217, prb_pkg::SPR_TAG};
  localparam logic [5:0] OPC_LIST [14] = '{6'h24, 6'h25, 6'h26, 6'h27, 6'h2c, 6'h2d, 6'h2f,
    6'h34, 6'h35, 6'h36, 6'h37, 6'h0e, 6'h18, 6'h20};
  logic        clk, reset_n, tick_clk, instr_valid, exc_take, exc_data_fault, ret_req;
  logic        msr_we, mq_we, result_valid, priv_exc, align_exc, tmr_exc, ext_grant, ext_deny;
  logic        mem_write, resume_valid;
  logic [31:0] instr_word, instr_addr, gpr_data, exc_pc, exc_fault_addr, exc_fault_cause;
  logic [31:0] msr_wdata, mq_wdata, result_data, resume_pc, msr_out, mq_out, pt_desc;
  logic [3:0]  proc_tag;
  logic        got_v, got_p, got_a, got_g, got_d, got_m, got_r;
  logic [31:0] got_data, d, pc;
  logic [31:0] sh [20];
  int          err_total, checks_done, cyc, tmr_hits;

  prb_top #(.VERSION_ID(VER)) DUT (.CLK(clk), .RESET_N(reset_n), .TICK_CLK(tick_clk),
    .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word), .INSTR_ADDR(instr_addr),
    .GPR_DATA(gpr_data), .EXC_TAKE(exc_take), .EXC_PC(exc_pc), .EXC_DATA_FAULT(exc_data_fault),
    .EXC_FAULT_ADDR(exc_fault_addr), .EXC_FAULT_CAUSE(exc_fault_cause), .RET_REQ(ret_req),
    .MSR_WE(msr_we), .MSR_WDATA(msr_wdata), .MQ_WE(mq_we), .MQ_WDATA(mq_wdata),
    .RESULT_DATA(result_data), .RESULT_VALID(result_valid), .PRIV_EXC(priv_exc),
    .ALIGN_EXC(align_exc), .TMR_EXC(tmr_exc), .EXT_GRANT(ext_grant), .EXT_DENY(ext_deny),
    .MEM_WRITE(mem_write), .RESUME_VALID(resume_valid), .RESUME_PC(resume_pc),
    .MSR_OUT(msr_out), .MQ_OUT(mq_out), .PT_DESC(pt_desc), .PROC_TAG(proc_tag));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  // timer pulses are counted on the falling edge, where they have settled
  always @(negedge clk) begin
    if (tmr_exc === 1'b1) tmr_hits = tmr_hits + 1;
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] mk(input logic [9:0] xo, input logic [9:0] spr);
    return {prb_pkg::OPC_XFORM, 5'h03, spr[4:0], spr[9:5], xo, 1'b0};
  endfunction : mk

  function automatic logic [31:0] expv(input logic [9:0] spr, input logic [31:0] v);
    return (spr == prb_pkg::SPR_TAG) ? (v & 32'h0000_000f) : v;
  endfunction : expv

  // collects every answer pulse over the two cycles after the taking edge
  task automatic watch;
    {got_v, got_p, got_a, got_g, got_d, got_m, got_r} = 7'h00;
    repeat (2) begin
      got_v |= result_valid;
      got_p |= priv_exc;
      got_a |= align_exc;
      got_g |= ext_grant;
      got_d |= ext_deny;
      got_m |= mem_write;
      got_r |= resume_valid;
      if (result_valid === 1'b1) got_data = result_data;
      @(posedge clk);
      #1;
    end
  endtask : watch

  task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] g);
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr_word  = w;
    instr_addr  = a;
    gpr_data    = g;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    instr_word  = $urandom;
    gpr_data    = $urandom;
    watch();
  endtask : issue

  task automatic mt(input logic [9:0] spr, input logic [31:0] v);
    issue(mk(prb_pkg::XO_MTSPR, spr), $urandom & 32'hffff_fffc, v);
  endtask : mt

  task automatic rd(input logic [9:0] spr, input logic [31:0] exp);
    got_data = ~exp;
    issue(mk(prb_pkg::XO_MFSPR, spr), $urandom & 32'hffff_fffc, 32'h0);
    chk({31'h0, got_v}, 32'h1);
    chk(got_data, exp);
  endtask : rd

  // 0 exception, 1 return, 2 machine state write, 3 extension write
  task automatic side(input int which, input logic [31:0] v);
    @(posedge clk);
    #1;
    exc_take = (which == 0);
    ret_req  = (which == 1);
    msr_we   = (which == 2);
    mq_we    = (which == 3);
    exc_pc = v;
    msr_wdata = v;
    mq_wdata = v;
    @(posedge clk);
    #1;
    {exc_take, ret_req, msr_we, mq_we} = 4'h0;
    watch();
  endtask : side

  task automatic tick;
    repeat (4) @(posedge clk);
    #1 tick_clk = 1'b1;
    repeat (4) @(posedge clk);
    #1 tick_clk = 1'b0;
    repeat (6) @(posedge clk);
  endtask : tick

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, tick_clk, instr_valid, exc_take, exc_data_fault, ret_req, msr_we, mq_we} = 8'h00;
    {instr_word, instr_addr, gpr_data, exc_pc, msr_wdata, mq_wdata} = '0;
    exc_fault_addr = 32'h0;
    exc_fault_cause = 32'h0;
    {err_total, checks_done, cyc, tmr_hits} = '0;
    reset_n = 1'b0;
    void'($urandom(86634));
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    chk(msr_out, prb_pkg::MSR_RST);
    chk(mq_out | pt_desc | {28'h0, proc_tag}, 32'h0);
    rd(prb_pkg::SPR_TMR, prb_pkg::TMR_RST);
    rd(prb_pkg::SPR_VERSION, VER);
    mt(prb_pkg::SPR_VERSION, ~VER);
    rd(prb_pkg::SPR_VERSION, VER);
    for (int i = 0; i < 20; i++) begin
      sh[i] = (i == 0) ? 32'hffff_ffff : $urandom;
      mt(RW_LIST[i], sh[i]);
      rd(RW_LIST[i], expv(RW_LIST[i], sh[i]));
    end
    chk(mq_out, sh[0]);
    chk(pt_desc, sh[3]);
    chk({28'h0, proc_tag}, sh[19] & 32'h0000_000f);
    d = $urandom;
    side(3, d);
    rd(prb_pkg::SPR_MQ, d);
    chk(mq_out, d);
    mt(prb_pkg::SPR_CLK_UP_WR, 32'h0000_0005);
    mt(prb_pkg::SPR_CLK_LO_WR, 32'hffff_ffff);
    mt(prb_pkg::SPR_CLK_UP_RD, 32'h0000_0000);
    rd(prb_pkg::SPR_CLK_UP_RD, 32'h0000_0005);
    rd(prb_pkg::SPR_CLK_LO_RD, 32'hffff_ffff);
    mt(prb_pkg::SPR_TMR, 32'h0000_0001);
    mt(prb_pkg::SPR_TMR_USER, 32'h0000_0007);
    rd(prb_pkg::SPR_TMR_USER, 32'h0000_0001);
    tmr_hits = 0;
    tick();
    rd(prb_pkg::SPR_TMR, 32'h0000_0000);
    chk(32'(tmr_hits), 32'h0);
    tick();
    chk(32'(tmr_hits), 32'h1);
    rd(prb_pkg::SPR_TMR, 32'hffff_ffff);
    rd(prb_pkg::SPR_CLK_UP_RD, 32'h0000_0006);
    rd(prb_pkg::SPR_CLK_LO_RD, 32'h0000_0001);
    for (int i = 1; i < 4; i++) begin
      issue(mk(prb_pkg::XO_MFSPR, prb_pkg::SPR_TAG), ($urandom & 32'hffff_fffc) | i, 32'h0);
      chk({30'h0, got_a, got_v}, 32'h2);
    end
    for (int i = 0; i < 14; i++) begin
      issue({OPC_LIST[i], 26'($urandom)}, $urandom & 32'hffff_fffc, $urandom);
      chk({31'h0, got_m}, {31'h0, i < 11});
    end
    issue(mk(prb_pkg::XO_STWX, 10'h000), 32'h0000_0100, 32'h0);
    chk({31'h0, got_m}, 32'h1);
    mt(prb_pkg::SPR_EXT_CTRL, 32'h7fff_ffff);
    issue(mk(prb_pkg::XO_EXT_IN, 10'h000), 32'h0000_0200, 32'h0);
    chk({30'h0, got_g, got_d}, 32'h1);
    mt(prb_pkg::SPR_EXT_CTRL, 32'h8000_0000);
    issue(mk(prb_pkg::XO_EXT_OUT, 10'h000), 32'h0000_0204, 32'h0);
    chk({30'h0, got_g, got_d}, 32'h2);
    side(2, 32'h0000_4000);
    chk(msr_out, 32'h0000_4000);
    for (int i = 0; i < 20; i++) begin
      issue(mk(prb_pkg::XO_MFSPR, RW_LIST[i]), 32'h0000_0300, 32'h0);
      chk({30'h0, got_p, got_v}, (i == 0) ? 32'h1 : 32'h2);
      if (i == 0) chk(got_data, d);
      mt(RW_LIST[i], $urandom);
      chk({31'h0, got_p}, 32'h1);
    end
    mt(prb_pkg::SPR_CLK_LO_WR, 32'h0);
    chk({31'h0, got_p}, 32'h1);
    issue(mk(prb_pkg::XO_MFSPR, prb_pkg::SPR_TMR), 32'h0000_0304, 32'h0);
    chk({30'h0, got_p, got_v}, 32'h2);
    rd(prb_pkg::SPR_TMR_USER, 32'hffff_ffff);
    rd(prb_pkg::SPR_CLK_LO_RD, 32'h0000_0001);
    pc = $urandom & 32'hffff_fffc;
    exc_data_fault = 1'b1;
    exc_fault_addr = $urandom;
    exc_fault_cause = $urandom;
    side(0, pc);
    exc_data_fault = 1'b0;
    chk(msr_out & 32'h0000_4000, 32'h0);
    rd(prb_pkg::SPR_RET_ADDR, pc);
    rd(prb_pkg::SPR_SAVED_ST, 32'h0000_4000);
    rd(prb_pkg::SPR_FADDR, exc_fault_addr);
    rd(prb_pkg::SPR_CAUSE, exc_fault_cause);
    for (int i = 6; i < 10; i++) rd(RW_LIST[i], sh[i]);
    side(1, 32'h0);
    chk({31'h0, got_r}, 32'h1);
    chk(resume_pc, pc);
    chk(msr_out, 32'h0000_4000);
    report_and_stop();
  end
endmodule : prb_top_bench
